//--- include/jlei_pkg.sv
/*
 * jlei_pkg: register map, field positions and reset values for the
 * jack and level event interrupt block.
 * Assumes the codec control interface delivers 8-bit register accesses
 * as a one-cycle strobe with an 8-bit address.
 */
package jlei_pkg;
    // ==========================================================
    // register addresses
    localparam logic [7:0] JLEI_ADDR_LVL_EN    = 8'h50;
    localparam logic [7:0] JLEI_ADDR_LVL_THR   = 8'h51;
    localparam logic [7:0] JLEI_ADDR_LIVE      = 8'hec;
    localparam logic [7:0] JLEI_ADDR_EVENTS    = 8'hed;
    localparam logic [7:0] JLEI_ADDR_MASKS     = 8'hee;
    // ==========================================================
    // field positions and widths
    localparam int         JLEI_BIT_JACK       = 7;
    localparam int         JLEI_BIT_LVL        = 0;
    localparam int         JLEI_LVL_EN_W       = 4;
    localparam int         JLEI_THR_W          = 7;
    // ==========================================================
    // reset values
    localparam logic [3:0] JLEI_RST_LVL_EN     = 4'h0;
    localparam logic [6:0] JLEI_RST_THR        = 7'h7f;
    localparam logic [7:0] JLEI_RD_ZERO        = 8'h00;
endpackage

//--- src/jlei_sync3.sv
/*
 * jlei_sync3: three-flop synchroniser for one asynchronous level.
 * Assumes the input is slow compared to CLK_I; output changes once the
 * second and third stages agree.
 */
`timescale 1ns/1ps
`default_nettype none
module jlei_sync3
(
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic async_i,
    output logic      level_o
);
    typedef struct packed
    {
        logic [2:0] stage;
        logic       level;
    } jlei_sync_s;

    jlei_sync_s cur;
    jlei_sync_s next_cur;

    // ==========================================================
    // shift and agree; first stage feeds only the second
    always_comb
    begin
        next_cur       = cur;
        next_cur.stage = {cur.stage[1:0], async_i};
        if (cur.stage[1] == cur.stage[2])
        begin
            next_cur.level = cur.stage[2];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign level_o = cur.level;
endmodule
`default_nettype wire

//--- src/jlei_top.sv
/*
 * jlei_top: headphone-jack and level-detect event latches, masks and
 * active-low interrupt pin, plus level-detect enables and threshold.
 * Assumes a register port on CLK_I: one-cycle write/read strobes, read
 * data valid the cycle after the read strobe. Jack and level-detect
 * inputs come from analogue front ends and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module jlei_top
    import jlei_pkg::*;
(
    input  wire logic                     CLK_I,
    input  wire logic                     RSTN_I,
    input  wire logic                     REG_WR_I,
    input  wire logic                     REG_RD_I,
    input  wire logic [7:0]               REG_ADDR_I,
    input  wire logic [7:0]               REG_WDATA_I,
    output logic      [7:0]               REG_RDATA_O,
    input  wire logic                     JACK_PRESENT_I,
    input  wire logic                     LVL_HIT_I,
    output logic [jlei_pkg::JLEI_LVL_EN_W-1:0] LVL_CH_EN_O,
    output logic [jlei_pkg::JLEI_THR_W-1:0]    LVL_THRESHOLD_O,
    output logic                          INTERRUPT_OUT_N_O
);
    import jlei_pkg::*;

    typedef struct packed
    {
        logic                    jack_prev;
        logic                    lvl_prev;
        logic                    jack_event;
        logic                    lvl_event;
        logic                    jack_msk;
        logic                    lvl_msk;
        logic [JLEI_LVL_EN_W-1:0] lvl_en;
        logic [JLEI_THR_W-1:0]    thr;
        logic [7:0]              rdata;
        logic                    irq_n;
    } jlei_state_s;

    jlei_state_s cur;
    jlei_state_s next_cur;
    logic        jack_sync;
    logic        lvl_sync;

    localparam jlei_state_s JLEI_RST_STATE = '{
        jack_prev: 1'b0, lvl_prev: 1'b0, jack_event: 1'b0, lvl_event: 1'b0,
        jack_msk: 1'b0, lvl_msk: 1'b0, lvl_en: JLEI_RST_LVL_EN,
        thr: JLEI_RST_THR, rdata: JLEI_RD_ZERO, irq_n: 1'b1};

    // ==========================================================
    // front-end synchronisers
    jlei_sync3 u_jack_sync
    (
        .clk_i   (CLK_I),
        .rstn_i  (RSTN_I),
        .async_i (JACK_PRESENT_I),
        .level_o (jack_sync)
    );

    jlei_sync3 u_lvl_sync
    (
        .clk_i   (CLK_I),
        .rstn_i  (RSTN_I),
        .async_i (LVL_HIT_I),
        .level_o (lvl_sync)
    );

    // ==========================================================
    // event latches, register writes, read mux, interrupt
    always_comb
    begin
        logic jack_edge;
        logic lvl_edge;
        logic clr_jack;
        logic clr_lvl;
        logic wr_ev;
        jack_edge = 1'b0;
        lvl_edge  = 1'b0;
        clr_jack  = 1'b0;
        clr_lvl   = 1'b0;
        wr_ev     = 1'b0;
        next_cur  = cur;
        next_cur.jack_prev = jack_sync;
        next_cur.lvl_prev  = lvl_sync;
        // insertion and removal both count as jack events
        jack_edge = jack_sync ^ cur.jack_prev;
        // level event only on a rising hit while some channel is enabled
        lvl_edge  = lvl_sync & ~cur.lvl_prev & (|cur.lvl_en);
        wr_ev     = REG_WR_I && (REG_ADDR_I == JLEI_ADDR_EVENTS);
        clr_jack  = wr_ev & REG_WDATA_I[JLEI_BIT_JACK];
        clr_lvl   = wr_ev & REG_WDATA_I[JLEI_BIT_LVL];
        // set wins over clear so no event is lost
        next_cur.jack_event = jack_edge | (cur.jack_event & ~clr_jack);
        next_cur.lvl_event  = lvl_edge | (cur.lvl_event & ~clr_lvl);
        if (REG_WR_I)
        begin
            unique case (REG_ADDR_I)
                JLEI_ADDR_MASKS:
                begin
                    next_cur.jack_msk = REG_WDATA_I[JLEI_BIT_JACK];
                    next_cur.lvl_msk  = REG_WDATA_I[JLEI_BIT_LVL];
                end
                JLEI_ADDR_LVL_EN:
                begin
                    next_cur.lvl_en = REG_WDATA_I[JLEI_LVL_EN_W-1:0];
                end
                JLEI_ADDR_LVL_THR:
                begin
                    next_cur.thr = REG_WDATA_I[JLEI_THR_W-1:0];
                end
                default:
                begin
                    next_cur.thr = cur.thr; // other addresses are not ours
                end
            endcase
        end
        if (REG_RD_I)
        begin
            next_cur.rdata = JLEI_RD_ZERO; // reserved and unmapped read 0
            unique case (REG_ADDR_I)
                JLEI_ADDR_LIVE:
                    next_cur.rdata[JLEI_BIT_JACK] = jack_sync;
                JLEI_ADDR_EVENTS:
                begin
                    next_cur.rdata[JLEI_BIT_JACK] = cur.jack_event;
                    next_cur.rdata[JLEI_BIT_LVL]  = cur.lvl_event;
                end
                JLEI_ADDR_MASKS:
                begin
                    next_cur.rdata[JLEI_BIT_JACK] = cur.jack_msk;
                    next_cur.rdata[JLEI_BIT_LVL]  = cur.lvl_msk;
                end
                JLEI_ADDR_LVL_EN:
                    next_cur.rdata[JLEI_LVL_EN_W-1:0] = cur.lvl_en;
                JLEI_ADDR_LVL_THR:
                    next_cur.rdata[JLEI_THR_W-1:0] = cur.thr;
                default:
                    next_cur.rdata = JLEI_RD_ZERO;
            endcase
        end
        // pin follows the registered latches, one cycle behind them
        next_cur.irq_n = ~((cur.jack_event & ~cur.jack_msk) |
                           (cur.lvl_event & ~cur.lvl_msk));
    end

    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            cur <= JLEI_RST_STATE;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign REG_RDATA_O       = cur.rdata;
    assign LVL_CH_EN_O       = cur.lvl_en;
    assign LVL_THRESHOLD_O   = cur.thr;
    assign INTERRUPT_OUT_N_O = cur.irq_n;

    // ==========================================================
    // checks
    a_jack_masked: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        cur.jack_msk && !cur.lvl_event |=> INTERRUPT_OUT_N_O)
        else $error("masked jack event reached pin");
    a_jack_irq: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        cur.jack_event && !cur.jack_msk |=> !INTERRUPT_OUT_N_O)
        else $error("unmasked jack event missing on pin");
    a_lvl_irq: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        cur.lvl_event && !cur.lvl_msk |=> !INTERRUPT_OUT_N_O)
        else $error("unmasked level event missing on pin");
    a_pin_release: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        !(cur.jack_event && !cur.jack_msk) && !(cur.lvl_event && !cur.lvl_msk)
        |=> INTERRUPT_OUT_N_O)
        else $error("pin low with no unmasked event");
    a_jack_clear: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        REG_WR_I && REG_ADDR_I == JLEI_ADDR_EVENTS && REG_WDATA_I[JLEI_BIT_JACK]
        && jack_sync == cur.jack_prev |=> !cur.jack_event)
        else $error("jack event not cleared by write 1");
    a_jack_hold: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        cur.jack_event && !(REG_WR_I && REG_ADDR_I == JLEI_ADDR_EVENTS
        && REG_WDATA_I[JLEI_BIT_JACK]) |=> cur.jack_event)
        else $error("jack event lost without clear");
    a_jack_set: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        jack_sync != cur.jack_prev |=> cur.jack_event)
        else $error("jack change not latched");
    a_live_read: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        REG_RD_I && REG_ADDR_I == JLEI_ADDR_LIVE
        |=> REG_RDATA_O[JLEI_BIT_JACK] == $past(jack_sync))
        else $error("live jack status misread");
    a_thr_write: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        REG_WR_I && REG_ADDR_I == JLEI_ADDR_LVL_THR
        |=> LVL_THRESHOLD_O == $past(REG_WDATA_I[JLEI_THR_W-1:0]))
        else $error("threshold not written");
    a_en_write: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        REG_WR_I && REG_ADDR_I == JLEI_ADDR_LVL_EN
        |=> LVL_CH_EN_O == $past(REG_WDATA_I[JLEI_LVL_EN_W-1:0]))
        else $error("channel enable not written");

    c_jack_irq: cover property (@(posedge CLK_I) disable iff (!RSTN_I)
        INTERRUPT_OUT_N_O ##1 !INTERRUPT_OUT_N_O ##[1:20] INTERRUPT_OUT_N_O);
    c_lvl_event: cover property (@(posedge CLK_I) disable iff (!RSTN_I)
        !cur.lvl_event ##1 cur.lvl_event);
    c_set_clear: cover property (@(posedge CLK_I) disable iff (!RSTN_I)
        REG_WR_I && REG_ADDR_I == JLEI_ADDR_EVENTS && jack_sync != cur.jack_prev);
endmodule
`default_nettype wire

//--- test/jlei_host_model.sv
/*
 * jlei_host_model: host side that watches the interrupt pin and counts
 * each new assertion of it.
 * Assumes the pin is sampled on the block's own clock.
 */
`timescale 1ns/1ps
`default_nettype none
module jlei_host_model
(
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       irq_n_i,
    output logic      [7:0] irq_count_o
);
    logic irq_n_prev;
    // ==========================================================
    // falling-edge counter, a level held low counts only once
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            irq_n_prev  <= 1'b1;
            irq_count_o <= 8'h00;
        end
        else
        begin
            irq_n_prev <= irq_n_i;
            if (irq_n_prev && !irq_n_i)
                irq_count_o <= irq_count_o + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- test/jack_level_event_irq_test.sv
/*
 * jack_level_event_irq_test: register tests for the event block.
 * Assumes the one-cycle strobe register port and a fixed event latency:
 * event 5 cycles after the pin, pin 1 cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module jack_level_event_irq_test;
    import jlei_pkg::*;
    logic       clk, rstn, wr, rd, jack, hit;
    logic [7:0] addr, wdata, rdata, irq_cnt;
    logic [3:0] ch_en;
    logic [6:0] thr;
    logic       irq_n;
    int         errors, num_checks, cyc;
    jlei_top i_dut (.CLK_I(clk), .RSTN_I(rstn), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
        .JACK_PRESENT_I(jack), .LVL_HIT_I(hit), .LVL_CH_EN_O(ch_en),
        .LVL_THRESHOLD_O(thr), .INTERRUPT_OUT_N_O(irq_n));
    jlei_host_model i_host (.clk_i(clk), .rstn_i(rstn), .irq_n_i(irq_n),
        .irq_count_o(irq_cnt));
    // ==========================================================
    // clock and hang guard; ceiling well above the short test run
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            give_verdict();
        end
    end
    // ==========================================================
    // register port tasks: strobe one cycle, data seen after the edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK(rdata, exp)
    endtask
    task automatic settle();
        repeat (8) @(posedge clk); // fixed event latency plus margin
        #1;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        // clock is owned by its own process, so it is not set here
        rstn       = 1'b0;
        wr         = 1'b0;
        rd         = 1'b0;
        jack       = 1'b0;
        hit        = 1'b0;
        addr       = 8'h00;
        wdata      = 8'h00;
        errors     = 0;
        num_checks = 0;
        cyc        = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        // reset values and unmapped read
        rd_chk(JLEI_ADDR_LVL_EN, 8'h00);
        rd_chk(JLEI_ADDR_LVL_THR, 8'h7f);
        rd_chk(JLEI_ADDR_LIVE, 8'h00);
        rd_chk(JLEI_ADDR_EVENTS, 8'h00);
        rd_chk(JLEI_ADDR_MASKS, 8'h00);
        rd_chk(8'h10, 8'h00);
        `CHK(thr, 7'h7f)
        `CHK(irq_n, 1'b1)
        $display("test reset done");
        // control fields: reserved bits dropped, boundary thresholds
        wr_reg(JLEI_ADDR_LVL_EN, 8'h5a);
        rd_chk(JLEI_ADDR_LVL_EN, 8'h0a);
        `CHK(ch_en, 4'ha)
        wr_reg(JLEI_ADDR_LVL_THR, 8'h00);
        rd_chk(JLEI_ADDR_LVL_THR, 8'h00);
        `CHK(thr, 7'h00)
        wr_reg(JLEI_ADDR_LVL_THR, 8'hff);
        rd_chk(JLEI_ADDR_LVL_THR, 8'h7f);
        wr_reg(JLEI_ADDR_LIVE, 8'hff);
        rd_chk(JLEI_ADDR_LIVE, 8'h00);
        $display("test control done");
        // jack insert: status, event, pin; write 0 keeps, write 1 clears
        @(posedge clk) jack <= 1'b1;
        settle();
        `CHK(irq_n, 1'b0)
        rd_chk(JLEI_ADDR_LIVE, 8'h80);
        rd_chk(JLEI_ADDR_EVENTS, 8'h80);
        wr_reg(JLEI_ADDR_EVENTS, 8'h01);
        rd_chk(JLEI_ADDR_EVENTS, 8'h80);
        wr_reg(JLEI_ADDR_EVENTS, 8'h80);
        settle();
        `CHK(irq_n, 1'b1)
        rd_chk(JLEI_ADDR_EVENTS, 8'h00);
        $display("test jack done");
        // masked jack removal stays off the pin until unmasked
        wr_reg(JLEI_ADDR_MASKS, 8'h80);
        @(posedge clk) jack <= 1'b0;
        settle();
        `CHK(irq_n, 1'b1)
        rd_chk(JLEI_ADDR_LIVE, 8'h00);
        rd_chk(JLEI_ADDR_EVENTS, 8'h80);
        rd_chk(JLEI_ADDR_MASKS, 8'h80);
        wr_reg(JLEI_ADDR_MASKS, 8'h00);
        settle();
        `CHK(irq_n, 1'b0)
        wr_reg(JLEI_ADDR_EVENTS, 8'h80);
        $display("test mask done");
        // level hit: ignored with all channels off, then latched
        wr_reg(JLEI_ADDR_LVL_EN, 8'h00);
        @(posedge clk) hit <= 1'b1;
        settle();
        rd_chk(JLEI_ADDR_EVENTS, 8'h00);
        @(posedge clk) hit <= 1'b0;
        wr_reg(JLEI_ADDR_LVL_EN, 8'h04);
        settle();
        @(posedge clk) hit <= 1'b1;
        settle();
        rd_chk(JLEI_ADDR_EVENTS, 8'h01);
        `CHK(irq_n, 1'b0)
        wr_reg(JLEI_ADDR_MASKS, 8'h01);
        settle();
        `CHK(irq_n, 1'b1)
        wr_reg(JLEI_ADDR_EVENTS, 8'h01);
        rd_chk(JLEI_ADDR_EVENTS, 8'h00);
        `CHK(irq_cnt, 8'h03)
        $display("test level done");
        give_verdict();
    end
endmodule
`default_nettype wire
